// >>> logic/rap_top.sv
// Purpose: clock-unit configuration registers and auto power control
// Assumes: indexed config port and i/o read port are on clk_i, pins are not
// Notes:   power request and power-good reset outputs are active low
`timescale 1ns/1ps
module rap_top
#(
  parameter logic [31:0] DLY_SHORT_CYC = rap_pkg::RAP_DLY_SHORT_CYC,
  parameter logic [31:0] DLY_LONG_CYC  = rap_pkg::RAP_DLY_LONG_CYC,
  parameter logic [31:0] RING_GAP_CYC  = rap_pkg::RAP_RING_GAP_CYC,
  parameter logic [31:0] RING_DUR_CYC  = rap_pkg::RAP_RING_DUR_CYC
)
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  // indexed configuration port
  input  wire logic [7:0]  cfg_index_i,
  input  wire logic        cfg_wr_i,
  input  wire logic        cfg_rd_i,
  input  wire logic [7:0]  cfg_wdata_i,
  output logic      [7:0]  cfg_rdata_o,
  // host i/o reads for range check
  input  wire logic [15:0] io_addr_i,
  input  wire logic        io_rd_i,
  output logic             io_hit_o,
  output logic      [7:0]  io_rdata_o,
  // pins
  input  wire logic        ring_input_one_i,
  input  wire logic        ring_input_two_i,
  input  wire logic        ring_ind_n_i,
  input  wire logic        switch_on_i,
  input  wire logic        switch_off_i,
  input  wire logic        battery_switch_i,
  input  wire logic        strap_input_three_i,
  // outputs
  output logic             power_on_request_n_o,
  output logic             power_good_reset_n_o,
  output logic             clock_unit_enable_o,
  output logic      [3:0]  irq_level_o,
  output logic             irq_drive_o
);
  import rap_pkg::*;

  typedef struct packed
  {
    logic        rtc_en;
    logic [1:0]  range_chk;
    logic [3:0]  base_hi;
    logic [6:0]  base_lo;
    logic [3:0]  irq_lvl;
    logic        batt;
    logic        mask;
    logic        por_en;
    logic        por_lvl;
    logic        dly21;
    logic [4:0]  cfg2;
    logic [3:0]  stat;
    rap_pwr_t    st;
    logic [31:0] tmr;
    logic        pwr_n;
    logic        por_pend;
    logic        por_pulse;
    logic [7:0]  rdata;
    logic        io_hit;
    logic [7:0]  io_rdata;
  } rap_state_t;

  rap_state_t q, d;

  logic [RAP_PIN_N-1:0] pin_raw, pin_lvl, pin_rise, pin_fall;
  logic                 ri1_rise, ri2_rise, sw_on, sw_off, batt_ev, strap;
  logic                 wr_act, wr_c1, wr_c2, swoff_cmd, activate;
  logic [15:0]          base;
  logic [7:0]           c1_read, c2_read, st_read;

  // every pin passes two flops before use
  assign pin_raw = {strap_input_three_i, battery_switch_i, switch_off_i, switch_on_i,
                    ring_ind_n_i, ring_input_two_i, ring_input_one_i};

  genvar g;
  generate
    for (g = 0; g < RAP_PIN_N; g++)
    begin : g_sync
      rap_pin_sync u_sync
      (
        .clk_i  (clk_i),
        .pin_i  (pin_raw[g]),
        .lvl_o  (pin_lvl[g]),
        .rise_o (pin_rise[g]),
        .fall_o (pin_fall[g])
      );
    end
  endgenerate

  assign ri1_rise = pin_rise[RAP_PIN_RI1];
  assign ri2_rise = pin_rise[RAP_PIN_RI2];
  assign sw_on    = pin_rise[RAP_PIN_SW_ON];
  assign sw_off   = pin_rise[RAP_PIN_SW_OFF];
  assign batt_ev  = pin_rise[RAP_PIN_BATT];
  assign strap    = pin_lvl[RAP_PIN_STRAP];

  // ring detector sits behind the interface
  rap_ring_if ring_bus ();

  assign ring_bus.fall       = pin_fall[RAP_PIN_RING_N];
  assign ring_bus.train_mode = q.cfg2[RAP_C2_TRAIN-2];

  rap_ring_det
  #(
    .GAP_CYC (RING_GAP_CYC),
    .DUR_CYC (RING_DUR_CYC)
  )
  u_ring
  (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .ring   (ring_bus.det)
  );

  // decoded strobes and derived values
  assign wr_act    = cfg_wr_i && (cfg_index_i == RAP_IDX_ACTIVATE);
  assign wr_c1     = cfg_wr_i && (cfg_index_i == RAP_IDX_CFG_ONE);
  assign wr_c2     = cfg_wr_i && (cfg_index_i == RAP_IDX_CFG_TWO);
  assign swoff_cmd = wr_c1 && cfg_wdata_i[RAP_C1_SWOFF];
  assign base      = {4'h0, q.base_hi, q.base_lo, 1'b0};
  // mask lets only the switch-on event through
  assign activate  = sw_on
                   | (!q.mask && ri2_rise && q.cfg2[RAP_C2_RI2EN-2])
                   | (!q.mask && ri1_rise && q.cfg2[RAP_C2_RI1EN-2])
                   | (!q.mask && ring_bus.detect && q.cfg2[RAP_C2_RNGEN-2]);

  // readback images; write-only and reserved bits read zero
  assign c1_read = {q.batt, 2'b00, q.mask, q.por_en, q.por_lvl, q.dly21, 1'b0};
  assign c2_read = {1'b0, q.cfg2, 2'b00};
  assign st_read = {2'b00, q.stat[3], 1'b0, q.stat[2:0], 1'b0};

  // single next-state process for registers and power sequencing
  always_comb
  begin
    d           = q;
    d.por_pulse = 1'b0;

    // register writes
    if (wr_act)
      d.rtc_en = cfg_wdata_i[0];
    if (cfg_wr_i && cfg_index_i == RAP_IDX_RANGE_CHK)
      d.range_chk = cfg_wdata_i[1:0];
    if (cfg_wr_i && cfg_index_i == RAP_IDX_BASE_HI)
      d.base_hi = cfg_wdata_i[3:0];
    if (cfg_wr_i && cfg_index_i == RAP_IDX_BASE_LO)
      d.base_lo = cfg_wdata_i[7:1];
    // invalid codes are dropped so the line stays defined
    if (cfg_wr_i && cfg_index_i == RAP_IDX_IRQ_LVL && cfg_wdata_i[3:0] < RAP_IRQ_FIRST_BAD)
      d.irq_lvl = cfg_wdata_i[3:0];
    if (wr_c1)
    begin
      d.mask    = cfg_wdata_i[RAP_C1_MASK];
      d.por_lvl = cfg_wdata_i[RAP_C1_PORLV];
      d.dly21   = cfg_wdata_i[RAP_C1_DLY21];
      if (cfg_wdata_i[RAP_C1_BATT])
        d.batt = 1'b0;
      if (cfg_wdata_i[RAP_C1_PORCL])
      begin
        d.por_en   = 1'b1;
        d.por_pend = 1'b0;
      end
    end
    if (wr_c2)
      d.cfg2 = cfg_wdata_i[RAP_C2_DLYEN:RAP_C2_TRAIN];

    // status clears on read; a new event below still wins
    if (cfg_rd_i && cfg_index_i == RAP_IDX_STATUS)
      d.stat = 4'h0;
    if (batt_ev)
      d.batt = 1'b1;
    if (sw_off)
      d.stat[3] = 1'b1;
    if (ri2_rise)
      d.stat[2] = 1'b1;
    if (ri1_rise)
      d.stat[1] = 1'b1;
    if (ring_bus.detect)
      d.stat[0] = 1'b1;

    // power request sequencing; software off has top priority
    case (q.st)
      RAP_OFF:
      begin
        if (activate && !swoff_cmd)
          d.st = RAP_ON;
      end
      RAP_ON:
      begin
        if (swoff_cmd)
          d.st = RAP_OFF;
        else if (sw_off && q.cfg2[RAP_C2_DLYEN-2])
        begin
          d.st  = RAP_HOLD;
          d.tmr = (q.dly21 ? DLY_LONG_CYC : DLY_SHORT_CYC) - 32'd1;
        end
        else if (sw_off)
          d.st = RAP_OFF;
      end
      RAP_HOLD:
      begin
        if (swoff_cmd)
          d.st = RAP_OFF;
        else if (activate)
          d.st = RAP_ON;
        else if (q.tmr == 32'd0)
          d.st = RAP_OFF;
        else
          d.tmr = q.tmr - 32'd1;
      end
      default:
      begin
        d.st = RAP_OFF;
      end
    endcase
    d.pwr_n = (d.st == RAP_OFF);

    // power-good reset fires as the request turns on
    if (q.st == RAP_OFF && d.st == RAP_ON && q.por_en)
    begin
      if (q.por_lvl)
        d.por_pend = 1'b1;
      else
        d.por_pulse = 1'b1;
    end

    // config readback, one cycle after the read strobe
    case (cfg_index_i)
      RAP_IDX_ACTIVATE:  d.rdata = {7'h00, q.rtc_en};
      RAP_IDX_RANGE_CHK: d.rdata = {6'h00, q.range_chk};
      RAP_IDX_BASE_HI:   d.rdata = base[15:8];
      RAP_IDX_BASE_LO:   d.rdata = base[7:0];
      RAP_IDX_IRQ_LVL:   d.rdata = {4'h0, q.irq_lvl};
      RAP_IDX_IRQ_TYPE:  d.rdata = RAP_IRQ_TYPE_VAL;
      RAP_IDX_CFG_ONE:   d.rdata = c1_read;
      RAP_IDX_CFG_TWO:   d.rdata = c2_read;
      RAP_IDX_STATUS:    d.rdata = st_read;
      default:           d.rdata = 8'h00;
    endcase
    if (!cfg_rd_i)
      d.rdata = 8'h00;

    // range check answers reads of the two-byte window
    d.io_hit   = io_rd_i && q.range_chk[RAP_RC_EN] && (io_addr_i[15:1] == base[15:1]);
    d.io_rdata = !d.io_hit ? 8'h00 : (q.range_chk[RAP_RC_PAT] ? RAP_RESP_SET : RAP_RESP_CLR);

    if (!nrst_i)
    begin
      d         = '0;
      d.rtc_en  = strap;
      d.base_hi = RAP_BASE_HI_RST[3:0];
      d.base_lo = RAP_BASE_LO_RST[7:1];
      d.irq_lvl = RAP_IRQ_LVL_RST;
      d.st      = RAP_OFF;
      d.pwr_n   = 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    q <= d;
  end

  // outputs from flops; power-good reset and irq drive pass through gates
  assign cfg_rdata_o          = q.rdata;
  assign io_hit_o             = q.io_hit;
  assign io_rdata_o           = q.io_rdata;
  assign power_on_request_n_o = q.pwr_n;
  assign power_good_reset_n_o = ~(q.por_pend | q.por_pulse);
  assign clock_unit_enable_o  = q.rtc_en;
  assign irq_level_o          = q.irq_lvl;
  assign irq_drive_o          = q.rtc_en && (q.irq_lvl != 4'h0);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_swoff_write;
    cfg_wr_i && cfg_index_i == RAP_IDX_CFG_ONE && cfg_wdata_i[RAP_C1_SWOFF];
  endsequence

  sequence s_read(logic [7:0] idx);
    cfg_rd_i && cfg_index_i == idx;
  endsequence

  property p_rtc_en;
    wr_act |=> clock_unit_enable_o == $past(cfg_wdata_i[0]);
  endproperty
  a_rtc_en: assert property (p_rtc_en) else $error("clock enable not written");

  property p_range_resp;
    (io_rd_i && q.range_chk == 2'b11 && io_addr_i[15:1] == base[15:1])
      |=> io_hit_o && io_rdata_o == RAP_RESP_SET;
  endproperty
  a_range_resp: assert property (p_range_resp) else $error("range check answer wrong");

  property p_base_hi;
    s_read(RAP_IDX_BASE_HI) |=> cfg_rdata_o[7:4] == 4'h0;
  endproperty
  a_base_hi: assert property (p_base_hi) else $error("base high upper bits not zero");

  property p_base_lo;
    s_read(RAP_IDX_BASE_LO) |=> !cfg_rdata_o[0];
  endproperty
  a_base_lo: assert property (p_base_lo) else $error("base low bit zero set");

  property p_irq_type;
    s_read(RAP_IDX_IRQ_TYPE) |=> cfg_rdata_o == RAP_IRQ_TYPE_VAL;
  endproperty
  a_irq_type: assert property (p_irq_type) else $error("irq type not constant");

  property p_swoff;
    s_swoff_write |=> power_on_request_n_o [*2];
  endproperty
  a_swoff: assert property (p_swoff) else $error("software off did not release");

  property p_mask;
    (q.st == RAP_OFF && q.mask && !sw_on && !wr_c1) |=> power_on_request_n_o;
  endproperty
  a_mask: assert property (p_mask) else $error("masked activation passed");

  property p_delay_hold;
    (q.st == RAP_ON && sw_off && q.cfg2[RAP_C2_DLYEN-2] && !swoff_cmd)
      |=> !power_on_request_n_o && q.st == RAP_HOLD;
  endproperty
  a_delay_hold: assert property (p_delay_hold) else $error("delayed release was immediate");

  property p_ri2;
    (q.st == RAP_OFF && ri2_rise && q.cfg2[RAP_C2_RI2EN-2] && !q.mask && !wr_c1)
      |=> !power_on_request_n_o;
  endproperty
  a_ri2: assert property (p_ri2) else $error("ring two did not activate");

  property p_swoff_flag;
    sw_off |=> q.stat[3];
  endproperty
  a_swoff_flag: assert property (p_swoff_flag) else $error("switch-off flag not set");

  property p_irq_none;
    irq_level_o == 4'h0 |-> !irq_drive_o;
  endproperty
  a_irq_none: assert property (p_irq_none) else $error("irq driven with code zero");
endmodule : rap_top

// >>> logic/rap_pkg.sv
// Purpose: constants for the clock-unit config and auto power control block
// Assumes: 100 MHz core clock, 8-bit indexed configuration registers
// Notes:   long cycle counts are defaults for top-level parameters
//
// Contract
// - activate bit 0 enables clock; strap sets reset
// - range check answers reads 55h or AAh
// - base high: bits 7-4 zero, 3-0 writable
// - base low: bits 7-1 writable, bit 0 zero
// - irq level code, reset 08h, Fh-Dh invalid
// - irq type register reads constant 02h
// - battery flag set by switch, write-one clears
// - write one to bit 5 drops power request
// - write one enables reset, clears level reset
// - bit 2 picks level or edge reset
// - bit 1 picks 21 or 5 second delay
// - delay enable defers release after switch-off
// - ring input two rise activates when enabled
// - ring input one rise activates when enabled
// - detected ring activates request when enabled
// - ring detect: train over 16Hz or edge
// - switch-off event sets sticky status flag
// - level code zero drives no interrupt line
package rap_pkg;

  // register indexes
  localparam logic [7:0] RAP_IDX_ACTIVATE  = 8'h30;
  localparam logic [7:0] RAP_IDX_RANGE_CHK = 8'h31;
  localparam logic [7:0] RAP_IDX_BASE_HI   = 8'h60;
  localparam logic [7:0] RAP_IDX_BASE_LO   = 8'h61;
  localparam logic [7:0] RAP_IDX_IRQ_LVL   = 8'h70;
  localparam logic [7:0] RAP_IDX_IRQ_TYPE  = 8'h71;
  localparam logic [7:0] RAP_IDX_CFG_ONE   = 8'hF0;
  localparam logic [7:0] RAP_IDX_CFG_TWO   = 8'hF1;
  localparam logic [7:0] RAP_IDX_STATUS    = 8'hF2;

  // reset and fixed values
  localparam logic [7:0] RAP_BASE_HI_RST   = 8'h00;
  localparam logic [7:0] RAP_BASE_LO_RST   = 8'h70;
  localparam logic [3:0] RAP_IRQ_LVL_RST   = 4'h8;
  localparam logic [7:0] RAP_IRQ_TYPE_VAL  = 8'h02;
  localparam logic [7:0] RAP_CFG_RST       = 8'h00;
  localparam logic [7:0] RAP_RESP_SET      = 8'h55;
  localparam logic [7:0] RAP_RESP_CLR      = 8'hAA;
  localparam logic [3:0] RAP_IRQ_FIRST_BAD = 4'hD;

  // field positions, config one
  localparam int RAP_C1_BATT  = 7;
  localparam int RAP_C1_SWOFF = 5;
  localparam int RAP_C1_MASK  = 4;
  localparam int RAP_C1_PORCL = 3;
  localparam int RAP_C1_PORLV = 2;
  localparam int RAP_C1_DLY21 = 1;
  // field positions, config two
  localparam int RAP_C2_DLYEN = 6;
  localparam int RAP_C2_RI2EN = 5;
  localparam int RAP_C2_RI1EN = 4;
  localparam int RAP_C2_RNGEN = 3;
  localparam int RAP_C2_TRAIN = 2;
  // field positions, status
  localparam int RAP_ST_SWOFF = 5;
  localparam int RAP_ST_RI2   = 3;
  localparam int RAP_ST_RI1   = 2;
  localparam int RAP_ST_RING  = 1;
  // range check fields
  localparam int RAP_RC_EN    = 1;
  localparam int RAP_RC_PAT   = 0;

  // pin slots of the synchroniser bank
  localparam int RAP_PIN_N      = 7;
  localparam int RAP_PIN_RI1    = 0;
  localparam int RAP_PIN_RI2    = 1;
  localparam int RAP_PIN_RING_N = 2;
  localparam int RAP_PIN_SW_ON  = 3;
  localparam int RAP_PIN_SW_OFF = 4;
  localparam int RAP_PIN_BATT   = 5;
  localparam int RAP_PIN_STRAP  = 6;

  // timing
  localparam longint RAP_CLK_HZ      = 100_000_000;
  localparam longint RAP_DLY_SHORT_S = 5;
  localparam longint RAP_DLY_LONG_S  = 21;
  localparam longint RAP_RING_MIN_HZ = 16;
  localparam longint RAP_RING_DUR_MS = 190;
  localparam logic [31:0] RAP_DLY_SHORT_CYC = 32'(RAP_DLY_SHORT_S * RAP_CLK_HZ);
  localparam logic [31:0] RAP_DLY_LONG_CYC  = 32'(RAP_DLY_LONG_S * RAP_CLK_HZ);
  localparam logic [31:0] RAP_RING_GAP_CYC  = 32'(RAP_CLK_HZ / RAP_RING_MIN_HZ);
  localparam logic [31:0] RAP_RING_DUR_CYC  = 32'((RAP_RING_DUR_MS * RAP_CLK_HZ + 999) / 1000);

  // power request states
  typedef enum logic [1:0]
  {
    RAP_OFF  = 2'b00,
    RAP_ON   = 2'b01,
    RAP_HOLD = 2'b10
  } rap_pwr_t;

endpackage : rap_pkg

// >>> logic/rap_ring_if.sv
// Purpose: carries ring edge, mode and detection between top and detector
// Assumes: single clock domain
// Notes:   detect is a one-cycle pulse
`timescale 1ns/1ps
interface rap_ring_if;
  logic fall;
  logic train_mode;
  logic detect;

  modport det (input fall, input train_mode, output detect);
  modport ctl (output fall, output train_mode, input detect);
endinterface : rap_ring_if

// >>> logic/rap_pin_sync.sv
// Purpose: two-flop synchroniser with edge pulses for one pin
// Assumes: pin is asynchronous to clk_i
// Notes:   stages carry no reset so a strap is valid during reset
`timescale 1ns/1ps
module rap_pin_sync
(
  // clock
  input  wire logic clk_i,
  // pin
  input  wire logic pin_i,
  // synchronised level and edges
  output logic      lvl_o,
  output logic      rise_o,
  output logic      fall_o
);
  typedef struct packed
  {
    logic s1;
    logic s2;
    logic s3;
  } rap_sync_t;

  rap_sync_t q, d;

  // first stage feeds only the second
  always_comb
  begin
    d    = q;
    d.s1 = pin_i;
    d.s2 = q.s1;
    d.s3 = q.s2;
  end

  always_ff @(posedge clk_i)
  begin
    q <= d;
  end

  assign lvl_o  = q.s2;
  assign rise_o = q.s2 & ~q.s3;
  assign fall_o = ~q.s2 & q.s3;
endmodule : rap_pin_sync

// >>> logic/rap_ring_det.sv
// Purpose: ring detection, single falling edge or sustained pulse train
// Assumes: fall is a synchronised one-cycle pulse
// Notes:   after a train detection the detector re-arms on the next edge
`timescale 1ns/1ps
module rap_ring_det
#(
  parameter logic [31:0] GAP_CYC = 32'd6250000,
  parameter logic [31:0] DUR_CYC = 32'd19000000
)
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic nrst_i,
  // ring signals
  rap_ring_if.det   ring
);
  typedef struct packed
  {
    logic        active;
    logic [31:0] gap;
    logic [31:0] run;
    logic        det;
  } rap_ring_t;

  rap_ring_t q, d;

  // gap watches the edge rate, run the train length
  always_comb
  begin
    d     = q;
    d.det = 1'b0;
    if (!ring.train_mode)
    begin
      d.active = 1'b0;
      d.det    = ring.fall;
    end
    else
    begin
      if (q.active)
      begin
        d.gap = q.gap + 32'd1;
        d.run = q.run + 32'd1;
        if (q.gap >= GAP_CYC - 32'd1)
          d.active = 1'b0; // rate fell to 16 Hz or below
      end
      if (ring.fall)
      begin
        d.gap = 32'd0;
        if (!q.active)
        begin
          d.active = 1'b1;
          d.run    = 32'd0;
        end
      end
      if (q.active && q.run >= DUR_CYC - 32'd1)
      begin
        d.det    = 1'b1;
        d.active = 1'b0;
      end
    end
    if (!nrst_i)
      d = '0;
  end

  always_ff @(posedge clk_i)
  begin
    q <= d;
  end

  assign ring.detect = q.det;

  property p_edge_mode;
    @(posedge clk_i) disable iff (!nrst_i)
    (!ring.train_mode && ring.fall) |=> ring.detect;
  endproperty
  a_edge_mode: assert property (p_edge_mode) else $error("edge ring not detected");

  property p_train_quiet;
    @(posedge clk_i) disable iff (!nrst_i)
    (ring.train_mode && !q.active) |=> !ring.detect;
  endproperty
  a_train_quiet: assert property (p_train_quiet) else $error("train detect without train");
endmodule : rap_ring_det

// >>> verif/rap_host_model.sv
// Purpose: host model, indexed config accesses and i/o reads
// Assumes: block samples strobes on the rising edge
// Notes:   drives at the falling edge; notes each expected read
`timescale 1ns/1ps
module rap_host_model
(
  // clock
  input  wire logic        clk_i,
  // config and i/o requests
  output logic      [7:0]  cfg_index_o,
  output logic             cfg_wr_o,
  output logic             cfg_rd_o,
  output logic      [7:0]  cfg_wdata_o,
  output logic      [15:0] io_addr_o,
  output logic             io_rd_o
);
  // expected results, oldest first
  logic [8:0] exp_q[$];

  // idle bus from time zero
  initial
  begin
    cfg_index_o = 8'h00;
    cfg_wr_o = 1'b0;
    cfg_rd_o = 1'b0;
    cfg_wdata_o = 8'h00;
    io_addr_o = 16'h0000;
    io_rd_o = 1'b0;
  end

  // one-cycle strobe, index and data held across the edge
  task automatic acc(input logic [7:0] i, input logic [7:0] d, input logic w);
    @(negedge clk_i);
    cfg_index_o = i;
    cfg_wdata_o = d;
    cfg_wr_o = w;
    cfg_rd_o = ~w;
    @(negedge clk_i);
    cfg_wr_o = 1'b0;
    cfg_rd_o = 1'b0;
  endtask : acc

  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    acc(i, d, 1'b1);
  endtask : wr

  task automatic rd(input logic [7:0] i, input logic [7:0] e);
    exp_q.push_back({1'b0, e});
    acc(i, ~e, 1'b0);
  endtask : rd

  // i/o read of the range-check window
  task automatic io(input logic [15:0] a, input logic h, input logic [7:0] e);
    exp_q.push_back({h, e});
    @(negedge clk_i);
    io_addr_o = a;
    io_rd_o = 1'b1;
    @(negedge clk_i);
    io_rd_o = 1'b0;
  endtask : io
endmodule : rap_host_model

// >>> verif/rap_top_tb.sv
// Purpose: self-checking bench for config registers and power control
// Assumes: short delay and ring parameters keep the run brief
// Notes:   host model queues read results, the monitor compares them
`timescale 1ns/1ps
module rap_top_tb;
  logic        clk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic [5:0]  pin = 6'h00;
  logic [7:0]  idx, wd, rdat, iod, hi, lo;
  logic        wr, rd, io_rd, hit, pon_n, pg_n, en, drv;
  logic        rd_d, io_d;
  logic        strap = 1'b1;
  logic [3:0]  lvl;
  logic [15:0] ioa, base;
  int          n_mismatch = 0;
  int          n_checks = 0;
  int          seed = 29;
  int          n_pg_lo = 0;

  initial
  begin
    forever #5 clk_i = ~clk_i;
  end

  rap_top #(.DLY_SHORT_CYC(32'd50), .DLY_LONG_CYC(32'd210), .RING_GAP_CYC(32'd20), .RING_DUR_CYC(32'd100)) u_dut
  (
    .clk_i(clk_i), .nrst_i(nrst_i), .cfg_index_i(idx), .cfg_wr_i(wr), .cfg_rd_i(rd), .cfg_wdata_i(wd),
    .cfg_rdata_o(rdat), .io_addr_i(ioa), .io_rd_i(io_rd), .io_hit_o(hit), .io_rdata_o(iod),
    .ring_input_one_i(pin[0]), .ring_input_two_i(pin[1]), .ring_ind_n_i(~pin[2]), .switch_on_i(pin[3]),
    .switch_off_i(pin[4]), .battery_switch_i(pin[5]), .strap_input_three_i(strap),
    .power_on_request_n_o(pon_n), .power_good_reset_n_o(pg_n), .clock_unit_enable_o(en),
    .irq_level_o(lvl), .irq_drive_o(drv)
  );

  rap_host_model u_host
  (
    .clk_i(clk_i), .cfg_index_o(idx), .cfg_wr_o(wr), .cfg_rd_o(rd), .cfg_wdata_o(wd),
    .io_addr_o(ioa), .io_rd_o(io_rd)
  );

  // results stand only in the cycle right after the strobe edge
  always @(posedge clk_i)
  begin
    rd_d <= rd;
    io_d <= io_rd;
  end

  // oldest note against what appeared
  always @(negedge clk_i)
  begin
    if (rd_d === 1'b1)
      chk("cfg_rdata", {1'b0, rdat}, u_host.exp_q.pop_front());
    if (io_d === 1'b1)
      chk("io_read", {hit, iod}, u_host.exp_q.pop_front());
  end

  // edge-type power-good reset must be low for exactly one cycle
  always @(negedge clk_i)
  begin
    if (pg_n === 1'b0)
      n_pg_lo++;
  end

  task automatic chk(input string nm, input logic [8:0] s, input logic [8:0] e);
    n_checks++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic pw(input logic e);
    chk("pwr_req_n", {8'h00, pon_n}, {8'h00, e});
  endtask : pw

  task automatic w2;
    repeat (2) @(negedge clk_i);
  endtask : w2

  // pins pass a two-flop sync, so hold well beyond three edges
  task automatic pulse(input int i);
    @(negedge clk_i);
    pin[i] = 1'b1;
    repeat (6) @(negedge clk_i);
    pin[i] = 1'b0;
    w2();
  endtask : pulse

  task automatic tally_and_finish;
    $display("mismatches %0d checks %0d", n_mismatch, n_checks);
    if (n_mismatch == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  // run is under two thousand cycles
  initial
  begin
    #100000;
    n_mismatch++;
    tally_and_finish();
  end

  initial
  begin
    repeat (10) @(negedge clk_i);
    nrst_i = 1'b1;
    chk("clk_en", {8'h00, en}, 9'h001);
    u_host.rd(8'h30, 8'h01);
    u_host.rd(8'h31, 8'h00);
    u_host.rd(8'h60, 8'h00);
    u_host.rd(8'h61, 8'h70);
    u_host.rd(8'h70, 8'h08);
    u_host.rd(8'hF0, 8'h00);
    u_host.rd(8'hF1, 8'h00);
    u_host.wr(8'h30, 8'h00);
    u_host.wr(8'h70, 8'h0E);
    u_host.rd(8'h70, 8'h08);
    u_host.wr(8'h70, 8'h0C);
    u_host.rd(8'h70, 8'h0C);
    u_host.wr(8'h71, 8'hFF);
    u_host.rd(8'h71, 8'h02);
    u_host.rd(8'h55, 8'h00);
    hi = 8'($random(seed));
    lo = 8'($random(seed));
    base = {4'h0, hi[3:0], lo[7:1], 1'b0};
    u_host.wr(8'h60, hi);
    u_host.wr(8'h61, lo);
    u_host.rd(8'h60, hi & 8'h0F);
    u_host.rd(8'h61, lo & 8'hFE);
    u_host.wr(8'h31, 8'h03);
    u_host.io(base, 1'b1, 8'h55);
    u_host.io(base + 16'h0001, 1'b1, 8'h55);
    u_host.wr(8'h31, 8'h02);
    u_host.io(base, 1'b1, 8'hAA);
    u_host.io(base + 16'h0002, 1'b0, 8'h00);
    u_host.wr(8'h31, 8'h00);
    u_host.wr(8'h30, 8'h01);
    u_host.wr(8'h70, 8'h00);
    w2();
    chk("clk_en", {8'h00, en}, 9'h001);
    chk("irq_drive", {8'h00, drv}, 9'h000);
    u_host.wr(8'h70, 8'h0C);
    w2();
    chk("irq_drive", {8'h00, drv}, 9'h001);
    chk("irq_level", {5'h00, lvl}, 9'h00C);
    // activation sources, masked then open
    u_host.wr(8'hF1, 8'h38);
    u_host.wr(8'hF0, 8'h10);
    for (int i = 0; i < 3; i++)
      pulse(i);
    pw(1'b1);
    pulse(3);
    pw(1'b0);
    u_host.wr(8'hF0, 8'h20);
    w2();
    pw(1'b1);
    u_host.rd(8'hF0, 8'h00);
    for (int i = 0; i < 3; i++)
    begin
      pulse(i);
      pw(1'b0);
      u_host.wr(8'hF0, 8'h20);
      w2();
      pw(1'b1);
    end
    u_host.rd(8'hF2, 8'h0E);
    // delayed and immediate switch-off
    u_host.wr(8'hF1, 8'h40);
    pulse(3);
    pulse(4);
    pw(1'b0);
    repeat (50) @(negedge clk_i);
    pw(1'b1);
    u_host.rd(8'hF2, 8'h20);
    u_host.wr(8'hF0, 8'h02);
    pulse(3);
    pulse(4);
    repeat (150) @(negedge clk_i);
    pw(1'b0);
    repeat (70) @(negedge clk_i);
    pw(1'b1);
    pulse(3);
    pulse(4);
    u_host.wr(8'hF0, 8'h22);
    w2();
    pw(1'b1);
    u_host.wr(8'hF1, 8'h38);
    pulse(3);
    pulse(4);
    pw(1'b1);
    // power-good reset, level then edge
    u_host.wr(8'hF0, 8'h0C);
    pulse(3);
    chk("pg_n", {8'h00, pg_n}, 9'h000);
    u_host.wr(8'hF0, 8'h28);
    w2();
    chk("pg_n", {8'h00, pg_n}, 9'h001);
    n_pg_lo = 0;
    pulse(3);
    chk("pg_n", {8'h00, pg_n}, 9'h001);
    chk("pg_pulse", 9'(n_pg_lo), 9'h001);
    pulse(5);
    u_host.rd(8'hF0, 8'h88);
    u_host.wr(8'hF0, 8'h20);
    u_host.rd(8'hF0, 8'h88);
    u_host.wr(8'hF0, 8'h80);
    u_host.rd(8'hF0, 8'h08);
    // train mode ignores a lone edge, takes a sustained train
    u_host.wr(8'hF1, 8'h0C);
    pulse(2);
    // wait past the train length so a lone edge cannot count
    repeat (120) @(negedge clk_i);
    pw(1'b1);
    repeat (16)
    begin
      pin[2] = ~pin[2];
      repeat (8) @(negedge clk_i);
    end
    w2();
    pw(1'b0);
    // second reset with the strap low: enable follows the strap
    strap = 1'b0;
    nrst_i = 1'b0;
    repeat (10) @(negedge clk_i);
    nrst_i = 1'b1;
    chk("clk_en", {8'h00, en}, 9'h000);
    u_host.rd(8'h30, 8'h00);
    w2();
    tally_and_finish();
  end
endmodule : rap_top_tb
